// ===== design/acs_cfg.svh
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// system clock rate
`define ACS_CLK_MHZ 20

// register byte offsets
`define ACS_OFS_CTRL 8'h00
`define ACS_OFS_ACQ 8'h04
`define ACS_OFS_PUMP 8'h08
`define ACS_OFS_RESULT 8'h0C
`define ACS_OFS_STATUS 8'h10
`define ACS_OFS_MASK 8'h14

// control register fields
`define ACS_CTRL_ON 0
`define ACS_CTRL_GO 1
`define ACS_CTRL_CHAN_LO 8
`define ACS_CTRL_CHAN_HI 13

// pump control register fields
`define ACS_PUMP_EN 0
`define ACS_PUMP_RDY 1

// status and mask fields
`define ACS_STS_DONE 0
`define ACS_STS_PUMP 1

// reset values
`define ACS_RST_ACQ 13'h0000
`define ACS_RST_CHAN 6'h00
`define ACS_RST_MASK 2'h0

// charge pump start-up, in ns, and in clock cycles rounded up
`define ACS_PUMP_START_NS 10000
`define ACS_PUMP_START_CYC \
    ((`ACS_PUMP_START_NS * `ACS_CLK_MHZ + 999) / 1000)

`endif

// ===== design/acs_pkg.sv
package acs_pkg;

    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_ACQ = 2'b01,
        ACS_CONV = 2'b10
    } acs_state_t;

    // state of the countdown timer
    typedef struct packed {
        logic [12:0] cnt;
        logic busy;
        logic done;
    } acs_tmr_t;

    // whole state of the sequencer
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic on;
        logic go;
        logic [5:0] chan;
        logic [12:0] acq;
        logic pump_en;
        logic pump_rdy;
        logic [11:0] result;
        logic [1:0] sts;
        logic [1:0] msk;
        logic irq;
        acs_state_t state;
        logic conv_start;
        logic sample;
        logic acq_start;
        logic pump_start;
    } acs_regs_t;

endpackage : acs_pkg

// ===== design/acs_sequencer.sv
`timescale 1ns/1ns
`include "acs_cfg.svh"

// Operation
// - writing one to start bit, with on bit also one, begins a conversion
// - end shows as start bit clear, done flag set, interrupt if the done bit is set in the mask register
// - full acquisition after channel selection before conversion begins
// - pump enable switches pump on, then start-up interval runs
// - pump ready bit set once pump output has settled
// - zero acquisition count disables hardware acquisition timing
module acs_sequencer
    import acs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic core_done_i,
    input wire logic [11:0] core_result_i,
    output logic conv_start_o,
    output logic sample_o,
    output logic [5:0] channel_o,
    output logic pump_on_o
);

    acs_regs_t r_reg;
    acs_regs_t r_next;
    logic acq_done;
    logic pump_done;
    logic acq_abort;
    logic pump_abort;

    // byte-lane mask from the select lines
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_mask

    // acquisition interval, counted in clock cycles
    acs_timer u_acq_tmr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(r_reg.acq_start),
        .abort_i(acq_abort),
        .count_i(r_reg.acq),
        .busy_o(),
        .done_o(acq_done)
    );

    // charge pump start-up interval
    acs_timer u_pump_tmr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(r_reg.pump_start),
        .abort_i(pump_abort),
        .count_i(13'(`ACS_PUMP_START_CYC)),
        .busy_o(),
        .done_o(pump_done)
    );

    // timers stop as soon as their owner is switched off
    assign acq_abort = ~r_reg.on;
    assign pump_abort = ~r_reg.pump_en;

    always_comb
    begin
        logic wr;
        logic [31:0] m;
        logic [31:0] wd;
        logic [31:0] ctl;
        logic [1:0] set_ev;
        wr = 1'b0;
        m = 32'h00000000;
        wd = 32'h00000000;
        ctl = 32'h00000000;
        set_ev = 2'h0;
        r_next = r_reg;
        r_next.conv_start = 1'b0;
        r_next.acq_start = 1'b0;
        r_next.pump_start = 1'b0;

        // classic slave: ack one cycle after strobe, write at the ack edge
        r_next.ack = wb_cyc_i & wb_stb_i & ~r_reg.ack;
        wr = wb_cyc_i & wb_stb_i & wb_we_i & r_reg.ack;
        m = lane_mask(wb_sel_i);
        wd = wb_dat_i & m;

        // read mux, registered every cycle; unmapped reads as zero
        r_next.rdat = 32'h00000000;
        case (wb_adr_i)
            `ACS_OFS_CTRL:
            begin
                r_next.rdat[`ACS_CTRL_ON] = r_reg.on;
                r_next.rdat[`ACS_CTRL_GO] = r_reg.go;
                r_next.rdat[`ACS_CTRL_CHAN_HI:`ACS_CTRL_CHAN_LO] = r_reg.chan;
            end
            `ACS_OFS_ACQ: r_next.rdat[12:0] = r_reg.acq;
            `ACS_OFS_PUMP:
            begin
                r_next.rdat[`ACS_PUMP_EN] = r_reg.pump_en;
                r_next.rdat[`ACS_PUMP_RDY] = r_reg.pump_rdy;
            end
            `ACS_OFS_RESULT: r_next.rdat[11:0] = r_reg.result;
            `ACS_OFS_STATUS: r_next.rdat[1:0] = r_reg.sts;
            `ACS_OFS_MASK: r_next.rdat[1:0] = r_reg.msk;
            default: r_next.rdat = 32'h00000000;
        endcase

        // control writes; channel and count frozen while busy so the
        // acquisition in flight always belongs to the chosen channel
        ctl = {18'h00000, r_reg.chan, 6'h00, r_reg.go, r_reg.on};
        ctl = (ctl & ~m) | wd;
        if (wr && wb_adr_i == `ACS_OFS_CTRL)
        begin
            r_next.on = ctl[`ACS_CTRL_ON];
            if (r_reg.state == ACS_IDLE)
                r_next.chan = ctl[`ACS_CTRL_CHAN_HI:`ACS_CTRL_CHAN_LO];
        end
        if (wr && wb_adr_i == `ACS_OFS_ACQ && r_reg.state == ACS_IDLE)
            r_next.acq = (r_reg.acq & ~m[12:0]) | wd[12:0];
        if (wr && wb_adr_i == `ACS_OFS_MASK)
            r_next.msk = (r_reg.msk & ~m[1:0]) | wd[1:0];

        if (wr && wb_adr_i == `ACS_OFS_PUMP && m[`ACS_PUMP_EN])
        begin
            r_next.pump_en = wd[`ACS_PUMP_EN];
            r_next.pump_start = wd[`ACS_PUMP_EN] & ~r_reg.pump_en;
        end
        if (!r_reg.pump_en)
            r_next.pump_rdy = 1'b0;
        else if (pump_done)
        begin
            r_next.pump_rdy = 1'b1;
            set_ev[`ACS_STS_PUMP] = 1'b1;
        end

        // conversion sequence
        case (r_reg.state)
            ACS_IDLE:
            begin
                if (wr && wb_adr_i == `ACS_OFS_CTRL && ctl[`ACS_CTRL_GO]
                    && ctl[`ACS_CTRL_ON])
                begin
                    r_next.go = 1'b1;
                    // acquire on the new channel first
                    if (r_reg.acq != 13'h0000)
                    begin
                        r_next.state = ACS_ACQ;
                        r_next.sample = 1'b1;
                        r_next.acq_start = 1'b1;
                    end
                    else
                    begin
                        r_next.state = ACS_CONV;
                        r_next.conv_start = 1'b1;
                    end
                end
            end
            ACS_ACQ:
            begin
                if (acq_done)
                begin
                    r_next.state = ACS_CONV;
                    r_next.sample = 1'b0;
                    r_next.conv_start = 1'b1;
                end
            end
            ACS_CONV:
            begin
                // go clears with the result, or when on is cleared below
                if (core_done_i)
                begin
                    r_next.result = core_result_i;
                    r_next.go = 1'b0;
                    set_ev[`ACS_STS_DONE] = 1'b1;
                    r_next.state = ACS_IDLE;
                end
            end
            default: r_next.state = ACS_IDLE;
        endcase

        // switching the converter off abandons a conversion, no flag
        if (!r_next.on)
        begin
            r_next.state = ACS_IDLE;
            r_next.go = 1'b0;
            r_next.sample = 1'b0;
            r_next.conv_start = 1'b0;
            r_next.acq_start = 1'b0;
            set_ev[`ACS_STS_DONE] = 1'b0;
        end

        // sticky status, write one to clear; a new event wins the clear
        if (wr && wb_adr_i == `ACS_OFS_STATUS)
            r_next.sts = r_reg.sts & ~wd[1:0];
        r_next.sts = r_next.sts | set_ev;
        r_next.irq = |(r_next.sts & r_next.msk);
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r_reg <= '0;
            r_reg.state <= ACS_IDLE;
            r_reg.acq <= `ACS_RST_ACQ;
            r_reg.chan <= `ACS_RST_CHAN;
            r_reg.msk <= `ACS_RST_MASK;
        end
        else
            r_reg <= r_next;
    end

    // all outputs straight from the state register
    assign wb_dat_o = r_reg.rdat;
    assign wb_ack_o = r_reg.ack;
    assign irq_o = r_reg.irq;
    assign conv_start_o = r_reg.conv_start;
    assign sample_o = r_reg.sample;
    assign channel_o = r_reg.chan;
    assign pump_on_o = r_reg.pump_en;

endmodule : acs_sequencer

// ===== design/acs_timer.sv
`timescale 1ns/1ns
`include "acs_cfg.svh"

module acs_timer
    import acs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic [12:0] count_i,
    output logic busy_o,
    output logic done_o
);

    acs_tmr_t t_reg;
    acs_tmr_t t_next;

    // count down; done pulses count_i + 1 cycles after start_i
    always_comb
    begin
        t_next = t_reg;
        t_next.done = 1'b0;
        if (abort_i)
        begin
            t_next.busy = 1'b0;
            t_next.cnt = 13'h0000;
        end
        else if (start_i)
        begin
            t_next.cnt = count_i;
            t_next.busy = (count_i != 13'h0000);
        end
        else if (t_reg.busy)
        begin
            if (t_reg.cnt == 13'h0001)
            begin
                t_next.busy = 1'b0;
                t_next.done = 1'b1;
            end
            t_next.cnt = t_reg.cnt - 13'h0001;
        end
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            t_reg <= '0;
        else
            t_reg <= t_next;
    end

    assign busy_o = t_reg.busy;
    assign done_o = t_reg.done;

endmodule : acs_timer

// ===== dv/acs_sequencer_asserts.sv
`timescale 1ns/1ns
module acs_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic irq_o,
    input wire logic core_done_i,
    input wire logic conv_start_o,
    input wire logic sample_o,
    input wire logic [5:0] channel_o,
    input wire logic pump_on_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic wr1, wr2, dn1, dn2;

    // recent writes and core results, as causes for output changes
    always_ff @(posedge clk_i)
    begin
        wr1 <= wb_ack_o && wb_we_i;
        wr2 <= wr1;
        dn1 <= core_done_i;
        dn2 <= dn1;
    end

    sequence s_pump_wr;
        wb_ack_o && wb_we_i && wb_adr_i == 8'h08 && wb_sel_i[0];
    endsequence
    property p_pump_on;
        s_pump_wr |=> pump_on_o == $past(wb_dat_i[0]);
    endproperty
    a_pump_on:
        assert property (p_pump_on) else $error("pump enable mismatch");

    property p_start_pulse;
        conv_start_o |=> !conv_start_o;
    endproperty
    a_start_pulse:
        assert property (p_start_pulse) else $error("start pulse long");

    // acquisition ends into conversion, or by an abort write
    property p_acq_end;
        $fell(sample_o) |-> conv_start_o || wr1;
    endproperty
    a_acq_end:
        assert property (p_acq_end) else $error("acquisition cut");

    property p_chan_hold;
        sample_o |=> $stable(channel_o);
    endproperty
    a_chan_hold:
        assert property (p_chan_hold) else $error("channel moved");

    // start follows acquisition or, untimed, the start write
    property p_no_wait;
        conv_start_o |-> $past(sample_o) || wr1;
    endproperty
    a_no_wait:
        assert property (p_no_wait) else $error("start without cause");

    // interrupt drops only after software writes
    property p_irq_fall;
        $fell(irq_o) |-> wr1 || wr2;
    endproperty
    a_irq_fall:
        assert property (p_irq_fall) else $error("irq dropped alone");

    // interrupt rises on a result, a write or the pump
    property p_irq_rise;
        $rose(irq_o) |-> dn1 || dn2 || wr1 || wr2 || pump_on_o;
    endproperty
    a_irq_rise:
        assert property (p_irq_rise) else $error("irq without cause");
endmodule : acs_chk

bind acs_sequencer acs_chk u_chk (.clk_i, .rst_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_ack_o, .irq_o, .core_done_i,
    .conv_start_o, .sample_o, .channel_o, .pump_on_o);

// ===== dv/testbench.sv
`timescale 1ns/1ns
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, core_done_i;
    logic conv_start_o, sample_o, pump_on_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [11:0] core_result_i, res;
    logic [5:0] channel_o, ch;
    int error_cnt, check_count, seed, acq, m, s, i;

    always #25 clk_i = ~clk_i;

    acs_sequencer uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o,
        .core_done_i, .core_result_i, .conv_start_o, .sample_o,
        .channel_o, .pump_on_o);

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] e, g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // a bound used up is a mismatch and ends the run
    task automatic tmo(input int k, lim);
        if (k >= lim)
        begin
            error_cnt++;
            wrap_up();
        end
    endtask : tmo

    // one classic cycle; returns at the ack edge, idle cycle before
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        tmo(k, 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus

    // cycles from start write to seen start pulse
    function automatic int lat(input int a);
        return (a == 0) ? 1 : a + 3;
    endfunction : lat

    initial
    begin
        seed = 32'hd67e;
        {wb_cyc_i, wb_stb_i, wb_we_i, core_done_i} = 4'h0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        core_result_i = 12'h000;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values, unmapped 0x18 included
        for (i = 0; i < 7; i++)
        begin
            bus(1'b0, 8'(i * 4), 32'h0);
            chk("reset", 32'h0, rd);
        end
        $display("reset test done");
        bus(1'b1, 8'h14, 32'h2);
        bus(1'b1, 8'h08, 32'h1);
        @(posedge clk_i);
        chk("pump_on", 32'h1, pump_on_o);
        bus(1'b0, 8'h08, 32'h0);
        chk("pump early", 32'h1, rd);
        for (m = 0; irq_o !== 1'b1 && m < 400; m++)
            @(posedge clk_i);
        tmo(m, 400);
        chk("pump startup", 32'h1, 32'(m > 190));
        bus(1'b0, 8'h08, 32'h0);
        chk("pump ready", 32'h3, rd);
        bus(1'b1, 8'h10, 32'h2);
        repeat (2) @(posedge clk_i);
        chk("irq clear", 32'h0, irq_o);
        bus(1'b1, 8'h08, 32'h0);
        $display("pump test done");
        for (i = 0; i < 6; i++)
        begin
            acq = (i < 2) ? i : $unsigned($random(seed)) % 40;
            ch = 6'($random(seed));
            res = 12'($random(seed));
            bus(1'b1, 8'h14, 32'(i != 3));
            bus(1'b1, 8'h04, 32'(acq));
            // untimed: select channel, wait acquisition, then start
            if (acq == 0)
            begin
                bus(1'b1, 8'h00, {18'h0, ch, 8'h01});
                repeat (156) @(posedge clk_i);
            end
            bus(1'b1, 8'h00, {18'h0, ch, 8'h03});
            s = 0;
            for (m = 0; conv_start_o !== 1'b1 && m < 100; m++)
            begin
                @(posedge clk_i);
                s += 32'(sample_o);
            end
            tmo(m, 100);
            chk("latency", 32'(lat(acq)), 32'(m));
            chk("acquire", 32'h1, 32'((acq == 0) ? s == 0 : s >= acq));
            chk("channel", 32'(ch), 32'(channel_o));
            bus(1'b0, 8'h00, 32'h0);
            chk("go busy", {18'h0, ch, 8'h03}, rd);
            core_result_i <= res;
            core_done_i <= 1'b1;
            @(posedge clk_i);
            core_done_i <= 1'b0;
            repeat (2) @(posedge clk_i);
            chk("irq", 32'(i != 3), 32'(irq_o));
            bus(1'b0, 8'h00, 32'h0);
            chk("go clear", {18'h0, ch, 8'h01}, rd);
            bus(1'b0, 8'h0C, 32'h0);
            chk("result", 32'(res), rd);
            bus(1'b0, 8'h10, 32'h0);
            chk("done flag", 32'h1, rd);
            bus(1'b1, 8'h10, 32'h1);
            repeat (2) @(posedge clk_i);
            chk("irq off", 32'h0, 32'(irq_o));
        end
        $display("conversion test done");
        // clearing on in mid-acquisition abandons it and leaves no flag
        bus(1'b1, 8'h04, 32'h14);
        bus(1'b1, 8'h00, {18'h0, ch, 8'h03});
        bus(1'b1, 8'h00, 32'h0);
        @(posedge clk_i);
        chk("abort sample", 32'h0, 32'(sample_o));
        repeat (30) @(posedge clk_i);
        bus(1'b0, 8'h10, 32'h0);
        chk("abort flag", 32'h0, rd);
        bus(1'b0, 8'h00, 32'h0);
        chk("abort go", {18'h0, ch, 8'h00}, rd);
        $display("abort test done");
        wrap_up();
    end
endmodule : testbench
